// ===== logic/fgi_unit.sv
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fgi_unit (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [fgi_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [fgi_pkg::DATA_W-1:0] pwdata_in,
  output logic [fgi_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic frame_close_in,
  input wire logic line_close_in,
  input wire logic volume_close_in,
  input wire logic encoder_b_in,
  input wire logic encoder_a_in,
  input wire logic trigger_in,
  input wire logic frame_start_in,
  input wire logic line_start_in,
  input wire logic volume_start_in,
  input wire logic buffer_error_in,
  input wire logic sync_lost_in,
  input wire logic packet_dropped_in,
  output logic host_irq_out
);
  fgi_reg_if reg_bus ();

  logic [fgi_pkg::DATA_W-1:0] event_vec;
  logic [fgi_pkg::DATA_W-1:0] clear_vec;
  logic [fgi_pkg::DATA_W-1:0] interrupt_status_flags;
  logic [fgi_pkg::DATA_W-1:0] interrupt_mask_bits_reg;
  logic [fgi_pkg::DATA_W-1:0] interrupt_write_protect_bits_reg;
  logic [fgi_pkg::DATA_W-1:0] global_interrupt_control;
  logic global_interrupt_enable_reg;
  logic summary;
  logic host_irq_reg;
  logic wr_status;
  logic wr_global;
  logic wr_mask;
  logic wr_wp;

  fgi_apb_slave u_apb (
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .reg_bus(reg_bus)
  );

  // event sources gathered into the status word layout
  always_comb begin
    event_vec = '0;
    event_vec[fgi_pkg::BIT_FRAME_CLOSED] = frame_close_in;
    event_vec[fgi_pkg::BIT_LINE_CLOSED] = line_close_in;
    event_vec[fgi_pkg::BIT_VOLUME_CLOSED] = volume_close_in;
    event_vec[fgi_pkg::BIT_ENC_B] = encoder_b_in;
    event_vec[fgi_pkg::BIT_ENC_A] = encoder_a_in;
    event_vec[fgi_pkg::BIT_TRIGGER] = trigger_in;
    event_vec[fgi_pkg::BIT_FRAME_START] = frame_start_in;
    event_vec[fgi_pkg::BIT_LINE_START] = line_start_in;
    event_vec[fgi_pkg::BIT_VOLUME_START] = volume_start_in;
    event_vec[fgi_pkg::BIT_BM_ERROR] = buffer_error_in;
    event_vec[fgi_pkg::BIT_SYNC_LOST] = sync_lost_in;
    event_vec[fgi_pkg::BIT_PKT_DROPPED] = packet_dropped_in;
    event_vec[fgi_pkg::BIT_FRAME_COMPAT] = frame_close_in;
  end

  assign wr_status = reg_bus.wr_en & reg_bus.sel[fgi_pkg::SEL_STATUS];
  assign wr_global = reg_bus.wr_en & reg_bus.sel[fgi_pkg::SEL_GLOBAL];
  assign wr_mask = reg_bus.wr_en & reg_bus.sel[fgi_pkg::SEL_MASK];
  assign wr_wp = reg_bus.wr_en & reg_bus.sel[fgi_pkg::SEL_WP];

  // write one to clear, except where write protection is set
  assign clear_vec = wr_status ?
    (reg_bus.wdata & ~interrupt_write_protect_bits_reg & fgi_pkg::SRC_VALID) : '0;

  fgi_event_capture u_cap (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .event_in(event_vec),
    .clear_in(clear_vec),
    .flags_out(interrupt_status_flags)
  );

  // mask word, one bit per source, reserved bits held at zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_mask_bits_reg <= fgi_pkg::RST_MASK;
    end else if (wr_mask) begin
      interrupt_mask_bits_reg <= reg_bus.wdata & fgi_pkg::SRC_VALID;
    end
  end

  // write-protect word, same layout as the mask
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_write_protect_bits_reg <= fgi_pkg::RST_WP;
    end else if (wr_wp) begin
      interrupt_write_protect_bits_reg <= reg_bus.wdata & fgi_pkg::SRC_VALID;
    end
  end

  // global enable, the only writable bit of the control word
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      global_interrupt_enable_reg <= fgi_pkg::RST_GLOBAL_EN;
    end else if (wr_global) begin
      global_interrupt_enable_reg <= reg_bus.wdata[fgi_pkg::BIT_GLOBAL_EN];
    end
  end

  // summary of all flags that the mask allows
  assign summary = |(interrupt_status_flags & interrupt_mask_bits_reg);

  always_comb begin
    global_interrupt_control = '0;
    global_interrupt_control[fgi_pkg::BIT_SUMMARY] = summary;
    global_interrupt_control[fgi_pkg::BIT_GLOBAL_EN] = global_interrupt_enable_reg;
  end

  // host interrupt, registered, high only if summary and enable were both set one cycle before
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_irq_reg <= 1'b0;
    end else begin
      host_irq_reg <= summary & global_interrupt_enable_reg;
    end
  end
  assign host_irq_out = host_irq_reg;

  // register read mux
  always_comb begin
    reg_bus.rdata = '0;
    unique case (1'b1)
      reg_bus.sel[fgi_pkg::SEL_STATUS]: reg_bus.rdata = interrupt_status_flags;
      reg_bus.sel[fgi_pkg::SEL_GLOBAL]: reg_bus.rdata = global_interrupt_control;
      reg_bus.sel[fgi_pkg::SEL_MASK]: reg_bus.rdata = interrupt_mask_bits_reg;
      reg_bus.sel[fgi_pkg::SEL_WP]: reg_bus.rdata = interrupt_write_protect_bits_reg;
      default: reg_bus.rdata = '0;
    endcase
  end

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  logic rd_global;
  assign rd_global = psel_in & penable_in & ~pwrite_in & (paddr_in == fgi_pkg::OFF_GLOBAL);

  property p_frame_closed;
    frame_close_in |=> interrupt_status_flags[fgi_pkg::BIT_FRAME_CLOSED];
  endproperty
  a_frame_closed: assert property (p_frame_closed) else $error("frame close not flagged");

  property p_line_closed;
    line_close_in |=> interrupt_status_flags[fgi_pkg::BIT_LINE_CLOSED];
  endproperty
  a_line_closed: assert property (p_line_closed) else $error("line close not flagged");

  property p_volume_closed;
    volume_close_in |=> interrupt_status_flags[fgi_pkg::BIT_VOLUME_CLOSED];
  endproperty
  a_volume_closed: assert property (p_volume_closed) else $error("volume close not flagged");

  property p_enc_b;
    encoder_b_in |=> interrupt_status_flags[fgi_pkg::BIT_ENC_B];
  endproperty
  a_enc_b: assert property (p_enc_b) else $error("encoder B not flagged");

  property p_enc_a;
    encoder_a_in |=> interrupt_status_flags[fgi_pkg::BIT_ENC_A];
  endproperty
  a_enc_a: assert property (p_enc_a) else $error("encoder A not flagged");

  property p_trigger;
    trigger_in |=> interrupt_status_flags[fgi_pkg::BIT_TRIGGER];
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger not flagged");

  property p_frame_start;
    frame_start_in |=> interrupt_status_flags[fgi_pkg::BIT_FRAME_START];
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start not flagged");

  property p_line_start;
    line_start_in |=> interrupt_status_flags[fgi_pkg::BIT_LINE_START];
  endproperty
  a_line_start: assert property (p_line_start) else $error("line start not flagged");

  property p_volume_start;
    volume_start_in |=> interrupt_status_flags[fgi_pkg::BIT_VOLUME_START];
  endproperty
  a_volume_start: assert property (p_volume_start) else $error("volume start not flagged");

  property p_errors;
    buffer_error_in |=> interrupt_status_flags[fgi_pkg::BIT_BM_ERROR];
  endproperty
  a_errors: assert property (p_errors) else $error("buffer error not flagged");

  property p_sync_lost;
    sync_lost_in |=> interrupt_status_flags[fgi_pkg::BIT_SYNC_LOST];
  endproperty
  a_sync_lost: assert property (p_sync_lost) else $error("sync loss not flagged");

  property p_pkt_dropped;
    packet_dropped_in |=> interrupt_status_flags[fgi_pkg::BIT_PKT_DROPPED];
  endproperty
  a_pkt_dropped: assert property (p_pkt_dropped) else $error("packet drop not flagged");

  property p_compat;
    $rose(interrupt_status_flags[fgi_pkg::BIT_FRAME_COMPAT]) |->
      interrupt_status_flags[fgi_pkg::BIT_FRAME_CLOSED] && $past(frame_close_in);
  endproperty
  a_compat: assert property (p_compat) else $error("compat flag not tied to frame close");

  property p_summary_read;
    rd_global |-> prdata_out[fgi_pkg::BIT_SUMMARY]
      == |(interrupt_status_flags & interrupt_mask_bits_reg);
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary bit wrong");

  property p_irq_needs_enable;
    !global_interrupt_enable_reg [*2] |-> !host_irq_out;
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq while disabled");

  property p_mask_write;
    wr_mask |=> interrupt_mask_bits_reg == ($past(pwdata_in) & fgi_pkg::SRC_VALID);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_wp_write;
    wr_wp |=> interrupt_write_protect_bits_reg == ($past(pwdata_in) & fgi_pkg::SRC_VALID);
  endproperty
  a_wp_write: assert property (p_wp_write) else $error("write-protect write lost");

  property p_protected_hold;
    (wr_status && interrupt_status_flags[fgi_pkg::BIT_FRAME_CLOSED]
      && interrupt_write_protect_bits_reg[fgi_pkg::BIT_FRAME_CLOSED])
      |=> interrupt_status_flags[fgi_pkg::BIT_FRAME_CLOSED];
  endproperty
  a_protected_hold: assert property (p_protected_hold) else $error("protected flag cleared");

  property p_sticky;
    (interrupt_status_flags[fgi_pkg::BIT_ENC_A] && !wr_status)
      |=> interrupt_status_flags[fgi_pkg::BIT_ENC_A];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without a write");

  property p_clear_works;
    (wr_status && pwdata_in[fgi_pkg::BIT_ENC_B] && !encoder_b_in
      && !interrupt_write_protect_bits_reg[fgi_pkg::BIT_ENC_B])
      |=> !interrupt_status_flags[fgi_pkg::BIT_ENC_B];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("flag not cleared");

  property p_irq_follows;
    ##1 host_irq_out == $past(summary && global_interrupt_enable_reg);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not summary and enable");

  property p_reserved_zero;
    ((interrupt_status_flags | interrupt_mask_bits_reg
      | interrupt_write_protect_bits_reg) & ~fgi_pkg::SRC_VALID) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  c_irq_raised: cover property (global_interrupt_enable_reg && trigger_in ##2 host_irq_out);
  c_clear_race: cover property (wr_status && pwdata_in[fgi_pkg::BIT_TRIGGER] && trigger_in);
  c_protected: cover property (wr_status && (pwdata_in & interrupt_write_protect_bits_reg
    & interrupt_status_flags) != '0);
  c_unmapped: cover property (pslverr_out);
endmodule
`default_nettype wire

// ===== logic/fgi_pkg.sv
`default_nettype none
package fgi_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_REGS = 4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_WP = 12'h00c;
  localparam int unsigned SEL_STATUS = 0;
  localparam int unsigned SEL_GLOBAL = 1;
  localparam int unsigned SEL_MASK = 2;
  localparam int unsigned SEL_WP = 3;
  localparam int unsigned BIT_FRAME_CLOSED = 0;
  localparam int unsigned BIT_LINE_CLOSED = 1;
  localparam int unsigned BIT_VOLUME_CLOSED = 2;
  localparam int unsigned BIT_ENC_B = 4;
  localparam int unsigned BIT_ENC_A = 5;
  localparam int unsigned BIT_TRIGGER = 6;
  localparam int unsigned BIT_FRAME_START = 7;
  localparam int unsigned BIT_LINE_START = 8;
  localparam int unsigned BIT_VOLUME_START = 9;
  localparam int unsigned BIT_BM_ERROR = 26;
  localparam int unsigned BIT_SYNC_LOST = 27;
  localparam int unsigned BIT_PKT_DROPPED = 28;
  localparam int unsigned BIT_FRAME_COMPAT = 29;
  localparam int unsigned BIT_SUMMARY = 7;
  localparam int unsigned BIT_GLOBAL_EN = 8;
  localparam logic [DATA_W-1:0] SRC_VALID = 32'h3c0003f7;
  localparam logic [DATA_W-1:0] RST_STATUS = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_MASK = 32'h00000000;
  localparam logic [DATA_W-1:0] RST_WP = 32'h00000000;
  localparam logic RST_GLOBAL_EN = 1'b0;
endpackage
`default_nettype wire

// ===== logic/fgi_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fgi_reg_if;
  logic wr_en;
  logic [fgi_pkg::NUM_REGS-1:0] sel;
  logic [fgi_pkg::DATA_W-1:0] wdata;
  logic [fgi_pkg::DATA_W-1:0] rdata;
  modport bus (output wr_en, output sel, output wdata, input rdata);
  modport regs (input wr_en, input sel, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== logic/fgi_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module fgi_apb_slave (
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [fgi_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [fgi_pkg::DATA_W-1:0] pwdata_in,
  output logic [fgi_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  fgi_reg_if.bus reg_bus
);
  logic hit;
  logic access;

  // address decode into a one-hot register select
  always_comb begin
    reg_bus.sel = '0;
    reg_bus.sel[fgi_pkg::SEL_STATUS] = (paddr_in == fgi_pkg::OFF_STATUS);
    reg_bus.sel[fgi_pkg::SEL_GLOBAL] = (paddr_in == fgi_pkg::OFF_GLOBAL);
    reg_bus.sel[fgi_pkg::SEL_MASK] = (paddr_in == fgi_pkg::OFF_MASK);
    reg_bus.sel[fgi_pkg::SEL_WP] = (paddr_in == fgi_pkg::OFF_WP);
  end

  assign hit = |reg_bus.sel;
  assign access = psel_in & penable_in;
  // zero wait states; unmapped addresses answer with an error
  assign pready_out = 1'b1;
  assign pslverr_out = access & ~hit;
  assign reg_bus.wr_en = access & pwrite_in & hit;
  assign reg_bus.wdata = pwdata_in;
  assign prdata_out = (access & ~pwrite_in & hit) ? reg_bus.rdata : '0;
endmodule
`default_nettype wire

// ===== logic/fgi_event_capture.sv
`timescale 1ns/1ps
`default_nettype none
module fgi_event_capture (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [fgi_pkg::DATA_W-1:0] event_in,
  input wire logic [fgi_pkg::DATA_W-1:0] clear_in,
  output logic [fgi_pkg::DATA_W-1:0] flags_out
);
  genvar i;
  generate
    for (i = 0; i < fgi_pkg::DATA_W; i++) begin : g_flag
      if (fgi_pkg::SRC_VALID[i]) begin : g_src
        logic flag_reg;
        // sticky flag; a new event wins over a clear in the same cycle
        always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
          if (!arst_n_in) begin
            flag_reg <= fgi_pkg::RST_STATUS[i];
          end else begin
            flag_reg <= event_in[i] | (flag_reg & ~clear_in[i]);
          end
        end
        assign flags_out[i] = flag_reg;
      end else begin : g_rsv
        assign flags_out[i] = 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== verification/fgi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fgi_host_model (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic host_irq_in,
  output var int irq_count_out
);
  logic irq_prev_reg;
  // host services one board interrupt per rise of the level
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_prev_reg <= 1'b0;
      irq_count_out <= 0;
    end else begin
      irq_prev_reg <= host_irq_in;
      if (host_irq_in && !irq_prev_reg) begin
        irq_count_out <= irq_count_out + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/fgi_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module fgi_unit_test;
  localparam int EV_BIT [12] = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 26, 27, 28};
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] ev = 12'h000;
  logic host_irq;
  int irq_count;
  int failures = 0;
  int num_checks = 0;

  fgi_unit DUT (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .frame_close_in(ev[0]), .line_close_in(ev[1]), .volume_close_in(ev[2]),
    .encoder_b_in(ev[3]), .encoder_a_in(ev[4]), .trigger_in(ev[5]),
    .frame_start_in(ev[6]), .line_start_in(ev[7]), .volume_start_in(ev[8]),
    .buffer_error_in(ev[9]), .sync_lost_in(ev[10]), .packet_dropped_in(ev[11]),
    .host_irq_out(host_irq)
  );

  fgi_host_model host (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .host_irq_in(host_irq),
    .irq_count_out(irq_count)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check32(32'h0, 32'h1, "pready never came");
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb_xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    logic err;
    apb_xfer(1'b0, a, 32'h0, rd, err);
    check32(rd, exp, what);
    check32({31'h0, err}, 32'h0, "mapped read flagged error");
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev <= 12'h001 << i;
    @(posedge sys_clk);
    ev <= 12'h000;
  endtask

  task automatic irq_chk(input logic exp, input string what);
    #1;
    check32({31'h0, host_irq}, {31'h0, exp}, what);
  endtask

  task automatic test_reset;
    logic [31:0] rd;
    logic err;
    rd_chk(fgi_pkg::OFF_STATUS, 32'h0, "status after reset");
    rd_chk(fgi_pkg::OFF_GLOBAL, 32'h0, "global after reset");
    rd_chk(fgi_pkg::OFF_MASK, 32'h0, "mask after reset");
    rd_chk(fgi_pkg::OFF_WP, 32'h0, "protect after reset");
    apb_xfer(1'b0, 12'h010, 32'h0, rd, err);
    check32({31'h0, err}, 32'h1, "unmapped read error");
    check32(rd, 32'h0, "unmapped read data");
    apb_xfer(1'b1, 12'h010, 32'hffffffff, rd, err);
    check32({31'h0, err}, 32'h1, "unmapped write error");
    rd_chk(fgi_pkg::OFF_MASK, 32'h0, "unmapped write ignored");
    $display("test reset done");
  endtask

  task automatic test_events;
    logic [31:0] exp;
    for (int i = 0; i < 12; i++) begin
      exp = 32'h1 << EV_BIT[i];
      if (i == 0) begin
        exp[29] = 1'b1;
      end
      pulse(i);
      rd_chk(fgi_pkg::OFF_STATUS, exp, "event flag");
      wr(fgi_pkg::OFF_STATUS, 32'h0);
      rd_chk(fgi_pkg::OFF_STATUS, exp, "flag held");
      wr(fgi_pkg::OFF_STATUS, exp);
      rd_chk(fgi_pkg::OFF_STATUS, 32'h0, "flag cleared");
    end
    $display("test events done");
  endtask

  task automatic test_reserved;
    wr(fgi_pkg::OFF_MASK, 32'hffffffff);
    rd_chk(fgi_pkg::OFF_MASK, fgi_pkg::SRC_VALID, "mask bits");
    wr(fgi_pkg::OFF_WP, 32'hffffffff);
    rd_chk(fgi_pkg::OFF_WP, fgi_pkg::SRC_VALID, "protect bits");
    wr(fgi_pkg::OFF_GLOBAL, 32'hffffffff);
    rd_chk(fgi_pkg::OFF_GLOBAL, 32'h00000100, "global bits");
    wr(fgi_pkg::OFF_GLOBAL, 32'h0);
    wr(fgi_pkg::OFF_MASK, 32'h0);
    wr(fgi_pkg::OFF_WP, 32'h0);
    $display("test reserved done");
  endtask

  task automatic test_protect;
    wr(fgi_pkg::OFF_WP, 32'h00000001);
    pulse(0);
    wr(fgi_pkg::OFF_STATUS, 32'h20000001);
    rd_chk(fgi_pkg::OFF_STATUS, 32'h00000001, "protected flag kept");
    wr(fgi_pkg::OFF_WP, 32'h0);
    wr(fgi_pkg::OFF_STATUS, 32'h00000001);
    rd_chk(fgi_pkg::OFF_STATUS, 32'h0, "unprotected flag cleared");
    $display("test protect done");
  endtask

  task automatic test_race;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= fgi_pkg::OFF_STATUS;
    pwdata <= 32'h00000040;
    @(posedge sys_clk);
    penable <= 1'b1;
    ev <= 12'h020;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= 12'h000;
    rd_chk(fgi_pkg::OFF_STATUS, 32'h00000040, "event beats clear");
    wr(fgi_pkg::OFF_STATUS, 32'h00000040);
    rd_chk(fgi_pkg::OFF_STATUS, 32'h0, "race flag cleared");
    $display("test race done");
  endtask

  task automatic test_mid_reset;
    wr(fgi_pkg::OFF_MASK, 32'h00000040);
    wr(fgi_pkg::OFF_GLOBAL, 32'h00000100);
    pulse(5);
    @(posedge sys_clk);
    irq_chk(1'b1, "irq before reset");
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    irq_chk(1'b0, "irq after reset");
    check32(irq_count, 32'd0, "host count after reset");
    rd_chk(fgi_pkg::OFF_STATUS, 32'h0, "status after mid reset");
    rd_chk(fgi_pkg::OFF_GLOBAL, 32'h0, "global after mid reset");
    rd_chk(fgi_pkg::OFF_MASK, 32'h0, "mask after mid reset");
    $display("test mid reset done");
  endtask

  task automatic test_irq;
    wr(fgi_pkg::OFF_MASK, 32'h00000040);
    pulse(3);
    rd_chk(fgi_pkg::OFF_GLOBAL, 32'h0, "masked flag in summary");
    pulse(5);
    rd_chk(fgi_pkg::OFF_GLOBAL, 32'h00000080, "summary set");
    irq_chk(1'b0, "irq without enable");
    wr(fgi_pkg::OFF_GLOBAL, 32'h00000100);
    @(posedge sys_clk);
    irq_chk(1'b1, "irq after enable");
    @(posedge sys_clk);
    #1;
    check32(irq_count, 32'd1, "host saw interrupt");
    wr(fgi_pkg::OFF_STATUS, 32'h00000040);
    @(posedge sys_clk);
    irq_chk(1'b0, "irq after clear");
    pulse(5);
    irq_chk(1'b0, "irq one edge after event");
    @(posedge sys_clk);
    irq_chk(1'b1, "irq two edges after event");
    wr(fgi_pkg::OFF_GLOBAL, 32'h0);
    @(posedge sys_clk);
    irq_chk(1'b0, "irq after disable");
    check32(irq_count, 32'd2, "host saw second interrupt");
    wr(fgi_pkg::OFF_STATUS, 32'hffffffff);
    wr(fgi_pkg::OFF_MASK, 32'h0);
    $display("test irq done");
  endtask

  initial begin
    #100000;
    failures++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    test_reset;
    test_events;
    test_reserved;
    test_protect;
    test_race;
    test_irq;
    test_mid_reset;
    print_verdict;
  end
endmodule
`default_nettype wire
